// >>> lvds_sample_input_formatter.v
// Overview of operation
// - Wide uses sixteen lines, byte uses eight
// - Width bit zero, when set, selects word-wide
// - Data captured on both clock edges
// - Frame or sync resyncs FIFO pointers
// - Strobe sampled on rising clock edges
// - Parity from frame on falling edge
// - Word mode alternates I and Q
// - Software sync only in word mode
// - Byte order I hi, I lo, Q hi, Q lo
// - Byte assembly aligned to strobe rise
// - Write-sync rise resets write pointer
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "formatter_map.vh"
module lvds_sample_input_formatter (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire CE,
  input wire DDR_INPUT_CLOCK,
  input wire [15:0] DATA_IN,
  input wire FRAME_IN,
  input wire SYNC_IN,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [`DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`DATA_W-1:0] RDATA,
  output reg [31:0] SAMPLE,
  output reg SAMPLE_VALID,
  output reg PARITY_BIT,
  output reg PARITY_VALID,
  output reg WR_PTR_SYNC,
  output reg RD_PTR_SYNC
);
  // Synchronised pins
  wire [18:0] pins_sync;
  wire clk_s;
  wire [15:0] data_s;
  wire frame_s;
  wire sync_s;

  sync_2ff #(
    .WIDTH(19)
  ) u_sync (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .d({DDR_INPUT_CLOCK, FRAME_IN, SYNC_IN, DATA_IN}),
    .q(pins_sync)
  );

  assign clk_s = pins_sync[18];
  assign frame_s = pins_sync[17];
  assign sync_s = pins_sync[16];
  assign data_s = pins_sync[15:0];

  // Registers
  reg [`DATA_W-1:0] parity_control_register;
  reg [`DATA_W-1:0] interface_control_register;
  reg [`DATA_W-1:0] sync_select_register;
  reg sif_sync_reg;

  wire wide_input_select;
  wire parity_ena;
  wire [1:0] fmt_sel;
  wire [3:0] fin_sel;
  wire [3:0] fout_sel;

  assign wide_input_select =
    interface_control_register[`BIT_WIDE_SEL];
  assign parity_ena = parity_control_register[`BIT_PARITY_ENA];
  assign fmt_sel = sync_select_register[`FLD_FMT_HI:`FLD_FMT_LO];
  assign fin_sel = sync_select_register[`FLD_FIN_HI:`FLD_FIN_LO];
  assign fout_sel = sync_select_register[`FLD_FOUT_HI:`FLD_FOUT_LO];

  // Edge detection of link clock
  reg clk_d_reg;
  wire rise;
  wire fall;
  assign rise = clk_s & ~clk_d_reg;
  assign fall = ~clk_s & clk_d_reg;

  // Strobe history
  reg strobe_d_reg;
  reg sif_pend_reg;
  reg frame_pend_reg;
  reg [15:0] rise_word_reg;
  reg [7:0] byte_hi_reg;
  reg [15:0] i_word_reg;
  reg [1:0] byte_cnt_reg;
  reg aligned_reg;
  reg [7:0] status_cnt_reg;

  wire strobe_fmt;
  wire fmt_is_sif;
  wire sif_ok;
  wire strobe_rise;
  wire fin_src;
  wire fout_src;
  wire frame_rise;
  wire sync_rise;
  reg frame_d_reg;
  reg sync_d_reg;

  assign fmt_is_sif = (fmt_sel == `FMT_SIF_A) ||
    (fmt_sel == `FMT_SIF_B);
  assign sif_ok = wide_input_select && fmt_is_sif &&
    (fin_sel == `SEL_SIF) && (fout_sel == `SEL_SIF);
  assign strobe_fmt = (fmt_sel == `FMT_SYNC) ? sync_s : frame_s;
  assign strobe_rise = strobe_fmt & ~strobe_d_reg;
  // Per-source history, so a select change gives no stale edge
  assign frame_rise = frame_s & ~frame_d_reg;
  assign sync_rise = sync_s & ~sync_d_reg;
  assign fin_src = (fin_sel == `SEL_SIF) ? (sif_ok & sif_pend_reg) :
    (fin_sel == `SEL_FRAME) ? frame_rise :
    (fin_sel == `SEL_SYNC) ? sync_rise : 1'b0;
  assign fout_src = (fout_sel == `SEL_SIF) ? (sif_ok & sif_pend_reg) :
    (fout_sel == `SEL_FRAME) ? frame_rise :
    (fout_sel == `SEL_SYNC) ? sync_rise : 1'b0;

  // Register bus
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      parity_control_register <= `RST_PARITY_CTRL;
      interface_control_register <= `RST_IFACE_CTRL;
      sync_select_register <= `RST_SYNC_SEL;
      sif_sync_reg <= 1'b0;
      RDATA <= 16'h0000;
    end else if (CE) begin
      sif_sync_reg <= WR && (ADDR == `ADDR_SIF_SYNC) &&
        WDATA[`BIT_SIF_SYNC];
      if (WR) begin
        case (ADDR)
          `ADDR_PARITY_CTRL: begin
            parity_control_register <= WDATA;
          end
          `ADDR_IFACE_CTRL: begin
            interface_control_register <= WDATA;
          end
          `ADDR_SYNC_SEL: begin
            sync_select_register <= WDATA;
          end
          default: begin
          end
        endcase
      end
      if (RD) begin
        case (ADDR)
          `ADDR_PARITY_CTRL: RDATA <= parity_control_register;
          `ADDR_IFACE_CTRL: RDATA <= interface_control_register;
          `ADDR_SYNC_SEL: RDATA <= sync_select_register;
          `ADDR_STATUS: RDATA <= {6'h00, aligned_reg, byte_cnt_reg,
            status_cnt_reg[6:0]};
          default: RDATA <= 16'h0000;
        endcase
      end else begin
        RDATA <= 16'h0000;
      end
    end
  end

  // Link-side datapath
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_d_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
      sif_pend_reg <= 1'b0;
      frame_pend_reg <= 1'b0;
      frame_d_reg <= 1'b0;
      sync_d_reg <= 1'b0;
      rise_word_reg <= 16'h0000;
      byte_hi_reg <= 8'h00;
      i_word_reg <= 16'h0000;
      byte_cnt_reg <= `BYTE_FIRST;
      aligned_reg <= 1'b0;
      status_cnt_reg <= 8'h00;
      SAMPLE <= 32'h00000000;
      SAMPLE_VALID <= 1'b0;
      PARITY_BIT <= 1'b0;
      PARITY_VALID <= 1'b0;
      WR_PTR_SYNC <= 1'b0;
      RD_PTR_SYNC <= 1'b0;
    end else if (CE) begin
      clk_d_reg <= clk_s;
      SAMPLE_VALID <= 1'b0;
      PARITY_VALID <= 1'b0;
      WR_PTR_SYNC <= 1'b0;
      RD_PTR_SYNC <= 1'b0;
      // Software sync held until next rising edge
      if (sif_sync_reg) begin
        sif_pend_reg <= 1'b1;
      end
      if (rise) begin
        strobe_d_reg <= strobe_fmt;
        frame_d_reg <= frame_s;
        sync_d_reg <= sync_s;
        frame_pend_reg <= frame_s;
        if (!sif_sync_reg) begin
          sif_pend_reg <= 1'b0;
        end
        WR_PTR_SYNC <= fin_src;
        RD_PTR_SYNC <= fout_src;
        rise_word_reg <= data_s;
        if (!wide_input_select) begin
          if (strobe_rise) begin
            aligned_reg <= 1'b1;
            byte_hi_reg <= data_s[7:0];
            byte_cnt_reg <= 2'h1;
            status_cnt_reg <= status_cnt_reg + 8'h01;
          end else begin
            byte_hi_reg <= data_s[7:0];
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
          end
        end
      end
      if (fall) begin
        if (parity_ena && frame_pend_reg) begin
          PARITY_BIT <= frame_s;
          PARITY_VALID <= 1'b1;
        end
        frame_pend_reg <= 1'b0;
        if (wide_input_select) begin
          // I on rise, Q on fall
          SAMPLE <= {rise_word_reg, data_s};
          SAMPLE_VALID <= 1'b1;
        end else begin
          byte_cnt_reg <= byte_cnt_reg + 2'h1;
          if (byte_cnt_reg == 2'h1) begin
            i_word_reg <= {byte_hi_reg, data_s[7:0]};
          end else if (byte_cnt_reg == `BYTE_LAST && aligned_reg) begin
            SAMPLE <= {i_word_reg, byte_hi_reg, data_s[7:0]};
            SAMPLE_VALID <= 1'b1;
          end
        end
      end
    end
  end
endmodule // lvds_sample_input_formatter
`default_nettype wire

// >>> formatter_map.vh
`ifndef FORMATTER_MAP_VH
`define FORMATTER_MAP_VH

// Register addresses
`define ADDR_W 7
`define DATA_W 16
`define ADDR_PARITY_CTRL 7'h01
`define ADDR_IFACE_CTRL 7'h02
`define ADDR_SYNC_SEL 7'h20
`define ADDR_STATUS 7'h21
`define ADDR_SIF_SYNC 7'h22

// Field positions
`define BIT_PARITY_ENA 0
`define BIT_WIDE_SEL 0
`define FLD_FMT_LO 0
`define FLD_FMT_HI 1
`define FLD_FIN_LO 4
`define FLD_FIN_HI 7
`define FLD_FOUT_LO 8
`define FLD_FOUT_HI 11
`define BIT_SIF_SYNC 0

// Reset values
`define RST_PARITY_CTRL 16'h0000
`define RST_IFACE_CTRL 16'h0001
`define RST_SYNC_SEL 16'h0000

// Sync source select codes
`define SEL_SYNC 4'h1
`define SEL_FRAME 4'h2
`define SEL_SIF 4'h8
`define FMT_FRAME 2'h0
`define FMT_SYNC 2'h1
`define FMT_SIF_A 2'h2
`define FMT_SIF_B 2'h3

// Byte phase counts
`define BYTE_LAST 2'h3
`define BYTE_FIRST 2'h0

`endif

// >>> sync_2ff.v
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_reg;

  // Two-stage synchroniser, first stage read only by second
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sync_2ff
`default_nettype wire

// >>> src_model.sv
`timescale 1ns/1ps
`default_nettype none
module src_model (
  output var logic ck,
  output var logic [15:0] d,
  output var logic fr,
  output var logic sy
);
  initial begin
    ck = 0;
    d = 0;
    fr = 0;
    sy = 0;
  end
  task automatic send(input logic [15:0] a, b, input logic f1, f2, s);
    #1.3 d = a;
    fr = f1;
    sy = s;
    #40 ck = 1;
    #40 d = b;
    fr = f2;
    sy = 0;
    #40 ck = 0;
    #40 d = ~b;
  endtask
endmodule // src_model
`default_nettype wire

// >>> fmt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fmt_monitor (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic DDR_INPUT_CLOCK,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic [31:0] SAMPLE,
  input wire logic SAMPLE_VALID,
  input wire logic PARITY_VALID,
  input wire logic WR_PTR_SYNC,
  input wire logic RD_PTR_SYNC
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not idle");
  chk_sample_hold: assert property (!SAMPLE_VALID |-> $stable(SAMPLE))
    else $error("sample moved without valid");
  chk_sample_pulse: assert property (SAMPLE_VALID |=> !SAMPLE_VALID)
    else $error("sample valid too long");
  chk_sample_fall: assert property (SAMPLE_VALID |-> !$past(DDR_INPUT_CLOCK, 2))
    else $error("sample not after falling edge");
  chk_parity_pulse: assert property (PARITY_VALID |=> !PARITY_VALID)
    else $error("parity valid too long");
  chk_parity_fall: assert property (PARITY_VALID |-> !$past(DDR_INPUT_CLOCK, 2))
    else $error("parity not after falling edge");
  chk_wptr_pulse: assert property (WR_PTR_SYNC |=> !WR_PTR_SYNC)
    else $error("write sync too long");
  chk_rptr_pulse: assert property (RD_PTR_SYNC |=> !RD_PTR_SYNC)
    else $error("read sync too long");
endmodule // fmt_monitor
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic SYS_CLK = 0, ARST_N = 0, CE = 1, WR = 0, RD = 0;
  logic [6:0] ADDR = 0;
  logic [15:0] WDATA = 0, RDATA, DATA_IN, v;
  logic [31:0] SAMPLE, got;
  logic DDR_INPUT_CLOCK, FRAME_IN, SYNC_IN, SAMPLE_VALID, PARITY_BIT;
  logic PARITY_VALID, WR_PTR_SYNC, RD_PTR_SYNC;
  int fail_count = 0, checked = 0, cycles = 0, n_w = 0, n_r = 0, n_s = 0;
  initial forever #2 SYS_CLK = ~SYS_CLK;
  src_model src_model_i (.ck(DDR_INPUT_CLOCK), .d(DATA_IN), .fr(FRAME_IN),
    .sy(SYNC_IN));
  lvds_sample_input_formatter lvds_sample_input_formatter_i (.SYS_CLK,
    .ARST_N, .CE, .DDR_INPUT_CLOCK, .DATA_IN, .FRAME_IN, .SYNC_IN, .ADDR,
    .WDATA, .WR, .RD, .RDATA, .SAMPLE, .SAMPLE_VALID, .PARITY_BIT,
    .PARITY_VALID, .WR_PTR_SYNC, .RD_PTR_SYNC);
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (WR_PTR_SYNC === 1'b1) n_w <= n_w + 1;
    if (RD_PTR_SYNC === 1'b1) n_r <= n_r + 1;
    if (SAMPLE_VALID === 1'b1) n_s <= n_s + 1;
    if (SAMPLE_VALID === 1'b1) got <= SAMPLE;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1;
    @(posedge SYS_CLK);
    WR <= 0;
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge SYS_CLK);
    RD <= 0;
    @(negedge SYS_CLK);
    check("rdata", RDATA, e);
  endtask
  task automatic clr;
    @(negedge SYS_CLK);
    n_w = 0;
    n_r = 0;
    n_s = 0;
  endtask
  task automatic syncs(input int w, r);
    repeat (8) @(negedge SYS_CLK);
    check("wr sync", n_w, w);
    check("rd sync", n_r, r);
  endtask
  task automatic t_reset;
    wr(7'h10, 16'hFFFF);
    rdchk(7'h01, 16'h0000);
    rdchk(7'h02, 16'h0001);
    rdchk(7'h20, 16'h0000);
    rdchk(7'h10, 16'h0000);
  endtask
  task automatic t_word;
    clr;
    src_model_i.send(16'hA5C3, 16'h0F1E, 0, 0, 0);
    check("word", got, 32'hA5C30F1E);
    src_model_i.send(16'h8001, 16'h7FFE, 0, 0, 0);
    check("word", got, 32'h80017FFE);
    check("count", n_s, 2);
  endtask
  task automatic t_parity;
    wr(7'h01, 16'h0001);
    src_model_i.send(16'h1111, 16'h2222, 1, 1, 0);
    check("parity", PARITY_BIT, 1);
    src_model_i.send(16'h3333, 16'h4444, 1, 0, 0);
    check("parity", PARITY_BIT, 0);
  endtask
  task automatic t_ptr;
    wr(7'h20, 16'h0220);
    src_model_i.send(16'h0000, 16'h0000, 0, 0, 0);
    clr;
    src_model_i.send(16'h0001, 16'h0002, 1, 0, 0);
    syncs(1, 1);
    wr(7'h20, 16'h0211);
    clr;
    src_model_i.send(16'h0003, 16'h0004, 0, 0, 1);
    syncs(1, 0);
    wr(7'h20, 16'h0882);
    clr;
    wr(7'h22, 16'h0001);
    src_model_i.send(16'h0005, 16'h0006, 0, 0, 0);
    syncs(1, 1);
    wr(7'h02, 16'h0000);
    clr;
    wr(7'h22, 16'h0001);
    src_model_i.send(16'h0007, 16'h0008, 0, 0, 0);
    syncs(0, 0);
  endtask
  task automatic t_byte;
    wr(7'h20, 16'h0000);
    src_model_i.send(16'h00AB, 16'h00CD, 1, 0, 0);
    src_model_i.send(16'h00EF, 16'h0012, 0, 0, 0);
    check("byte", got, 32'hABCDEF12);
    src_model_i.send(16'h0034, 16'h0056, 0, 0, 0);
    src_model_i.send(16'h0078, 16'h009A, 0, 0, 0);
    check("byte", got, 32'h3456789A);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge SYS_CLK);
    ARST_N <= 1;
    t_reset;
    t_word;
    t_parity;
    t_ptr;
    t_byte;
    end_of_test;
  end
endmodule // testbench
bind lvds_sample_input_formatter fmt_monitor fmt_monitor_i (.SYS_CLK,
  .ARST_N, .DDR_INPUT_CLOCK, .RD, .RDATA, .SAMPLE, .SAMPLE_VALID,
  .PARITY_VALID, .WR_PTR_SYNC, .RD_PTR_SYNC);
`default_nettype wire
